// File: pkg/tbg_pkg.sv
// Constants shared by the timebase generation and routing block
package tbg_pkg;

  // Sizes of the routed signal groups and the register address width
  localparam int NUM_TRIG = 8;
  localparam int NUM_PFI  = 6;
  localparam int NUM_CTR  = 2;
  localparam int AW       = 12;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL    = 12'h000;
  localparam logic [AW-1:0] OFS_CTR_SRC = 12'h004;
  localparam logic [AW-1:0] OFS_TRIG    = 12'h008;
  localparam logic [AW-1:0] OFS_STATUS  = 12'h00C;

  // Control register fields
  localparam int CTRL_SRC_EXT = 0;
  localparam int CTRL_REF_LO  = 4;
  localparam int CTRL_DRV_EN  = 8;
  localparam int CTRL_DRV_LO  = 9;
  localparam int CTRL_STAR_EN = 12;
  localparam int CTRL_AI_SLOW = 13;
  localparam int CTRL_AO_SLOW = 14;

  // Trigger routing register fields
  localparam int TRIG_KIND_LO = 0;
  localparam int TRIG_LINE_LO = 2;
  localparam int TRIG_EXP_EN  = 8;
  localparam int TRIG_EXP_LO  = 9;

  // Status register fields
  localparam int STAT_LOCK     = 0;
  localparam int STAT_EXT      = 1;
  localparam int STAT_RUN      = 2;
  localparam int STAT_CONFLICT = 3;

  // Reset values
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_CTR_SRC = 32'h0000_0000;
  localparam logic [31:0] RST_TRIG    = 32'h0000_0000;

  // Reference source codes; 0 to 7 pick a shared trigger bus line
  localparam logic [3:0] REF_SEL_CLK10 = 4'h8;
  localparam logic [3:0] REF_SEL_STAR  = 4'h9;

  // Start trigger source kinds
  localparam logic [1:0] KIND_INT  = 2'h0;
  localparam logic [1:0] KIND_BUS  = 2'h1;
  localparam logic [1:0] KIND_PFI  = 2'h2;
  localparam logic [1:0] KIND_STAR = 2'h3;

  // Timebase choices for counters and sample timing
  localparam logic [1:0] CSEL_FAST = 2'h0;
  localparam logic [1:0] CSEL_MID  = 2'h1;
  localparam logic [1:0] CSEL_SLOW = 2'h2;

  // Frequencies and the divisions derived from them
  localparam int TB_FAST_HZ = 80_000_000;
  localparam int TB_MID_HZ  = 20_000_000;
  localparam int REF_HZ     = 10_000_000;
  localparam int MID_DIV    = TB_FAST_HZ / TB_MID_HZ;
  localparam int SLOW_DIV   = 200;
  localparam int REF_HALF   = TB_FAST_HZ / REF_HZ / 2;

endpackage

// File: hw/tbg_tick_div.sv
// Modulo tick divider with synchronous clear
`timescale 1ns/1ps

module tbg_tick_div #(
  parameter int MOD = 4
) (
  input  wire logic clk_in,    // System clock
  input  wire logic rst_n_in,  // Asynchronous reset, active low
  input  wire logic clr_in,    // Return count to zero
  input  wire logic tick_in,   // Input tick strobe
  output logic      tick_out   // One tick per MOD input ticks
);

  localparam int CW = (MOD > 1) ? $clog2(MOD) : 1;

  logic [CW-1:0] cnt_r;
  logic          wrap_c;

  assign wrap_c   = (cnt_r == CW'(MOD - 1));
  // Same-cycle strobe keeps divided ticks on a fast tick edge
  assign tick_out = tick_in && wrap_c && !clr_in;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_r <= '0;
    else if (clr_in)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= wrap_c ? '0 : cnt_r + 1'b1;
  end

endmodule // tbg_tick_div

// File: hw/tbg_timebase_top.sv
// Timebase generation, reference routing and APB control registers
`timescale 1ns/1ps

// Function
// - Fast timebase comes from oscillator or external reference, by source select.
// - Middle timebase is the fast timebase divided down, 20 MHz from 80.
// - Slow timebase is the middle timebase divided by 200, giving 100 kHz.
// - External reference picks any trigger bus line, backplane 10 MHz, or star.
// - With external reference, all timebases follow the phase-locked loop output.
// - 10 MHz reference output divides the oscillator, whatever source is chosen.
// - 10 MHz reference can be driven onto any one trigger bus line.
// - Each of the three timebases is selectable as a counter source.
// - Sample timing uses the middle timebase by default, slow one optionally.
// - Start timing comes from own logic, trigger bus, inputs, or star.
// - Initiator drives its reference on a line; all boards select that line.
// - As star controller, the device drives the star line with a clock.
// - Boards share one start trigger over the bus, with equal rates.
module tbg_timebase_top #(
  parameter int NCTR = tbg_pkg::NUM_CTR,  // Number of counters
  parameter int MDIV = tbg_pkg::MID_DIV,  // Fast to middle division
  parameter int SDIV = tbg_pkg::SLOW_DIV  // Middle to slow division
) (
  input  wire logic                      CLK_SYS_IN,      // 200 MHz clock
  input  wire logic                      RESET_N_IN,      // Async reset
  input  wire logic                      PSEL_IN,         // APB select
  input  wire logic                      PENABLE_IN,      // APB enable
  input  wire logic                      PWRITE_IN,       // APB direction
  input  wire logic [tbg_pkg::AW-1:0]    PADDR_IN,        // APB address
  input  wire logic [31:0]               PWDATA_IN,       // APB write data
  output logic      [31:0]               PRDATA_OUT,      // APB read data
  output logic                           PREADY_OUT,      // APB ready
  output logic                           PSLVERR_OUT,     // APB error
  input  wire logic                      OSC_TICK_IN,     // Oscillator tick
  input  wire logic                      PLL_TICK_IN,     // PLL tick
  input  wire logic                      PLL_LOCK_IN,     // PLL locked
  output logic                           EXT_REF_OUT,     // Reference to PLL
  input  wire logic [tbg_pkg::NUM_TRIG-1:0] TRIG_BUS_IN,  // Bus line levels
  output logic      [tbg_pkg::NUM_TRIG-1:0] TRIG_BUS_OUT, // Bus drive value
  output logic      [tbg_pkg::NUM_TRIG-1:0] TRIG_BUS_OE_OUT, // Bus enable
  input  wire logic                      PXI_CLK10_IN,    // Backplane clock
  input  wire logic                      PXI_STAR_IN,     // Star line level
  output logic                           PXI_STAR_OUT,    // Star drive value
  output logic                           PXI_STAR_OE_OUT, // Star enable
  input  wire logic [tbg_pkg::NUM_PFI-1:0] PFI_IN,        // Function inputs
  input  wire logic                      INT_START_IN,    // Own start
  output logic                           ACQ_START_OUT,   // Routed start
  output logic                           TB80_TICK_OUT,   // Fast tick
  output logic                           TB20_TICK_OUT,   // Middle tick
  output logic                           TB100K_TICK_OUT, // Slow tick
  output logic                           REF10_CLK_OUT,   // 10 MHz reference
  output logic                           AI_TB_TICK_OUT,  // Input timebase
  output logic                           AO_TB_TICK_OUT,  // Output timebase
  output logic      [NCTR-1:0]           CTR_TICK_OUT     // Counter sources
);

  import tbg_pkg::*;

  localparam int GW = $clog2(SDIV + 1);

  logic              src_ext_r;
  logic [3:0]        ref_sel_r;
  logic              drv_en_r;
  logic [2:0]        drv_line_r;
  logic              star_en_r;
  logic              ai_slow_r;
  logic              ao_slow_r;
  logic [2*NCTR-1:0] ctr_sel_r;
  logic [1:0]        start_kind_r;
  logic [2:0]        start_line_r;
  logic              exp_en_r;
  logic [2:0]        exp_line_r;
  logic              act_ext_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [31:0]       rd_word;
  logic              rd_err;
  logic              setup_ph;
  logic              wr_take;
  logic              run_c;
  logic              clr_c;
  logic              fast_c;
  logic              mid_c;
  logic              slow_c;
  logic              ref_t_c;
  logic              ref_clk_r;
  logic              ext_ref_c;
  logic              start_c;
  logic [NUM_TRIG-1:0] ref_hot;
  logic [NUM_TRIG-1:0] exp_hot;
  logic              conflict_c;
  logic              clr_q;
  logic [GW-1:0]     fast_gap_r;
  logic [GW-1:0]     mid_gap_r;

  function automatic logic [NUM_TRIG-1:0] line_hot(
    input logic       en,
    input logic [2:0] idx
  );
    line_hot = en ? (NUM_TRIG'(1) << idx) : '0;
  endfunction

  function automatic logic pick_tb(
    input logic [1:0] sel,
    input logic       f,
    input logic       m,
    input logic       s
  );
    case (sel)
      CSEL_FAST: pick_tb = f;
      CSEL_MID:  pick_tb = m;
      CSEL_SLOW: pick_tb = s;
      default:   pick_tb = 1'b0;
    endcase
  endfunction

  // APB slave: zero wait states, read data captured in setup phase
  assign setup_ph    = PSEL_IN && !PENABLE_IN;
  assign wr_take     = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign PRDATA_OUT  = prdata_r;
  assign PSLVERR_OUT = pslverr_r;

  always_comb
  begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (PADDR_IN)
      OFS_CTRL:
      begin
        rd_word[CTRL_SRC_EXT]         = src_ext_r;
        rd_word[CTRL_REF_LO +: 4]     = ref_sel_r;
        rd_word[CTRL_DRV_EN]          = drv_en_r;
        rd_word[CTRL_DRV_LO +: 3]     = drv_line_r;
        rd_word[CTRL_STAR_EN]         = star_en_r;
        rd_word[CTRL_AI_SLOW]         = ai_slow_r;
        rd_word[CTRL_AO_SLOW]         = ao_slow_r;
      end
      OFS_CTR_SRC: rd_word[2*NCTR-1:0] = ctr_sel_r;
      OFS_TRIG:
      begin
        rd_word[TRIG_KIND_LO +: 2]    = start_kind_r;
        rd_word[TRIG_LINE_LO +: 3]    = start_line_r;
        rd_word[TRIG_EXP_EN]          = exp_en_r;
        rd_word[TRIG_EXP_LO +: 3]     = exp_line_r;
      end
      OFS_STATUS:
      begin
        rd_word[STAT_LOCK]            = PLL_LOCK_IN;
        rd_word[STAT_EXT]             = act_ext_r;
        rd_word[STAT_RUN]             = run_c;
        rd_word[STAT_CONFLICT]        = conflict_c;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= PWRITE_IN ? '0 : rd_word;
      pslverr_r <= rd_err;
    end
  end

  // Clock source and routing control
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      src_ext_r  <= RST_CTRL[CTRL_SRC_EXT];
      ref_sel_r  <= RST_CTRL[CTRL_REF_LO +: 4];
      drv_en_r   <= RST_CTRL[CTRL_DRV_EN];
      drv_line_r <= RST_CTRL[CTRL_DRV_LO +: 3];
      star_en_r  <= RST_CTRL[CTRL_STAR_EN];
      ai_slow_r  <= RST_CTRL[CTRL_AI_SLOW];
      ao_slow_r  <= RST_CTRL[CTRL_AO_SLOW];
    end
    else if (wr_take && PADDR_IN == OFS_CTRL)
    begin
      src_ext_r  <= PWDATA_IN[CTRL_SRC_EXT];
      ref_sel_r  <= PWDATA_IN[CTRL_REF_LO +: 4];
      drv_en_r   <= PWDATA_IN[CTRL_DRV_EN];
      drv_line_r <= PWDATA_IN[CTRL_DRV_LO +: 3];
      star_en_r  <= PWDATA_IN[CTRL_STAR_EN];
      ai_slow_r  <= PWDATA_IN[CTRL_AI_SLOW];
      ao_slow_r  <= PWDATA_IN[CTRL_AO_SLOW];
    end
  end

  // Counter timebase choices
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ctr_sel_r <= RST_CTR_SRC[2*NCTR-1:0];
    else if (wr_take && PADDR_IN == OFS_CTR_SRC)
      ctr_sel_r <= PWDATA_IN[2*NCTR-1:0];
  end

  // Start trigger routing and export
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      start_kind_r <= RST_TRIG[TRIG_KIND_LO +: 2];
      start_line_r <= RST_TRIG[TRIG_LINE_LO +: 3];
      exp_en_r     <= RST_TRIG[TRIG_EXP_EN];
      exp_line_r   <= RST_TRIG[TRIG_EXP_LO +: 3];
    end
    else if (wr_take && PADDR_IN == OFS_TRIG)
    begin
      start_kind_r <= PWDATA_IN[TRIG_KIND_LO +: 2];
      start_line_r <= PWDATA_IN[TRIG_LINE_LO +: 3];
      exp_en_r     <= PWDATA_IN[TRIG_EXP_EN];
      exp_line_r   <= PWDATA_IN[TRIG_EXP_LO +: 3];
    end
  end

  // Timebase source: external path waits for PLL lock
  assign run_c  = !src_ext_r || PLL_LOCK_IN;
  // A source change or lost lock clears the middle and slow dividers at once
  assign clr_c  = !run_c || (src_ext_r != act_ext_r);
  assign fast_c = !clr_c &&
                  (src_ext_r ? PLL_TICK_IN : OSC_TICK_IN);

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      act_ext_r <= 1'b0;
    else
      act_ext_r <= src_ext_r;
  end

  tbg_tick_div #(.MOD(MDIV)) u_mid_div (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RESET_N_IN),
    .clr_in   (clr_c),
    .tick_in  (fast_c),
    .tick_out (mid_c)
  );

  tbg_tick_div #(.MOD(SDIV)) u_slow_div (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RESET_N_IN),
    .clr_in   (clr_c),
    .tick_in  (mid_c),
    .tick_out (slow_c)
  );

  // Reference divider runs from the oscillator only, never cleared
  tbg_tick_div #(.MOD(REF_HALF)) u_ref_div (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RESET_N_IN),
    .clr_in   (1'b0),
    .tick_in  (OSC_TICK_IN),
    .tick_out (ref_t_c)
  );

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ref_clk_r <= 1'b0;
    else if (ref_t_c)
      ref_clk_r <= ~ref_clk_r;
  end

  assign REF10_CLK_OUT = ref_clk_r;

  // Registered timebase outputs, all aligned to one edge
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      TB80_TICK_OUT   <= 1'b0;
      TB20_TICK_OUT   <= 1'b0;
      TB100K_TICK_OUT <= 1'b0;
      AI_TB_TICK_OUT  <= 1'b0;
      AO_TB_TICK_OUT  <= 1'b0;
    end
    else
    begin
      TB80_TICK_OUT   <= fast_c;
      TB20_TICK_OUT   <= mid_c;
      TB100K_TICK_OUT <= slow_c;
      AI_TB_TICK_OUT  <= pick_tb(ai_slow_r ? CSEL_SLOW : CSEL_MID,
                                 fast_c, mid_c, slow_c);
      AO_TB_TICK_OUT  <= pick_tb(ao_slow_r ? CSEL_SLOW : CSEL_MID,
                                 fast_c, mid_c, slow_c);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCTR; gi++)
    begin : g_ctr
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
      begin
        if (!RESET_N_IN)
          CTR_TICK_OUT[gi] <= 1'b0;
        else
          CTR_TICK_OUT[gi] <= pick_tb(ctr_sel_r[2*gi +: 2],
                                      fast_c, mid_c, slow_c);
      end
    end
  endgenerate

  // External reference selection toward the PLL
  always_comb
  begin
    if (!ref_sel_r[3])
      ext_ref_c = TRIG_BUS_IN[ref_sel_r[2:0]];
    else if (ref_sel_r == REF_SEL_CLK10)
      ext_ref_c = PXI_CLK10_IN;
    else if (ref_sel_r == REF_SEL_STAR)
      ext_ref_c = PXI_STAR_IN;
    else
      ext_ref_c = 1'b0;
  end

  // Start trigger source
  always_comb
  begin
    case (start_kind_r)
      KIND_BUS:  start_c = TRIG_BUS_IN[start_line_r];
      KIND_PFI:  start_c = (32'(start_line_r) < NUM_PFI) ?
                           PFI_IN[start_line_r] : 1'b0;
      KIND_STAR: start_c = PXI_STAR_IN;
      default:   start_c = INT_START_IN;
    endcase
  end

  // Reference drive wins a line over the exported start trigger
  assign ref_hot    = line_hot(drv_en_r, drv_line_r);
  assign exp_hot    = line_hot(exp_en_r, exp_line_r) & ~ref_hot;
  assign conflict_c = |(ref_hot & line_hot(exp_en_r, exp_line_r));

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      EXT_REF_OUT     <= 1'b0;
      ACQ_START_OUT   <= 1'b0;
      TRIG_BUS_OUT    <= '0;
      TRIG_BUS_OE_OUT <= '0;
      PXI_STAR_OUT    <= 1'b0;
      PXI_STAR_OE_OUT <= 1'b0;
    end
    else
    begin
      EXT_REF_OUT     <= ext_ref_c;
      ACQ_START_OUT   <= start_c;
      TRIG_BUS_OUT    <= (ref_hot & {NUM_TRIG{ref_clk_r}}) |
                         (exp_hot & {NUM_TRIG{INT_START_IN}});
      TRIG_BUS_OE_OUT <= ref_hot | exp_hot;
      PXI_STAR_OUT    <= star_en_r & ref_clk_r;
      PXI_STAR_OE_OUT <= star_en_r;
    end
  end

  // Tick spacing counters watched by the checks below
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      clr_q      <= 1'b0;
      fast_gap_r <= '0;
      mid_gap_r  <= '0;
    end
    else
    begin
      clr_q <= clr_c;
      if (clr_q)
        fast_gap_r <= '0;
      else if (TB80_TICK_OUT)
        fast_gap_r <= TB20_TICK_OUT ? '0 : fast_gap_r + 1'b1;
      if (clr_q)
        mid_gap_r <= '0;
      else if (TB20_TICK_OUT)
        mid_gap_r <= TB100K_TICK_OUT ? '0 : mid_gap_r + 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking

  default disable iff (!RESET_N_IN);

  a_fast_osc_src:
    assert property (!src_ext_r && !clr_c |=>
                     TB80_TICK_OUT == $past(OSC_TICK_IN))
    else $error("fast timebase does not follow the oscillator");

  a_mid_divide:
    assert property (TB20_TICK_OUT |->
                     TB80_TICK_OUT && fast_gap_r == GW'(MDIV - 1))
    else $error("middle tick not on every fourth fast tick");

  a_slow_divide:
    assert property (TB100K_TICK_OUT |->
                     TB20_TICK_OUT && mid_gap_r == GW'(SDIV - 1))
    else $error("slow tick not on every 200th middle tick");

  a_ref_pick_clk10:
    assert property (ref_sel_r == REF_SEL_CLK10 |=>
                     EXT_REF_OUT == $past(PXI_CLK10_IN))
    else $error("external reference not taken from backplane clock");

  a_pll_hold:
    assert property (src_ext_r && !PLL_LOCK_IN |=>
                     !TB80_TICK_OUT && !TB20_TICK_OUT && !TB100K_TICK_OUT)
    else $error("timebase ticks while the PLL is unlocked");

  a_ref_from_osc:
    assert property ($changed(ref_clk_r) |-> $past(OSC_TICK_IN))
    else $error("reference toggled without an oscillator tick");

  a_ref_on_bus:
    assert property (drv_en_r |=>
                     TRIG_BUS_OE_OUT[$past(drv_line_r)] &&
                     TRIG_BUS_OUT[$past(drv_line_r)] == $past(ref_clk_r))
    else $error("reference missing from the chosen bus line");

  a_ctr_fast_src:
    assert property (ctr_sel_r[1:0] == CSEL_FAST |=>
                     CTR_TICK_OUT[0] == TB80_TICK_OUT)
    else $error("counter source not the fast timebase");

  a_ai_mid_default:
    assert property (!ai_slow_r |=> AI_TB_TICK_OUT == TB20_TICK_OUT)
    else $error("input timing not on the middle timebase");

  a_start_from_star:
    assert property (start_kind_r == KIND_STAR |=>
                     ACQ_START_OUT == $past(PXI_STAR_IN))
    else $error("start trigger not routed from the star line");

  a_star_clock:
    assert property (star_en_r |=>
                     PXI_STAR_OE_OUT && PXI_STAR_OUT == $past(ref_clk_r))
    else $error("star line not driven with the reference clock");

  a_start_export:
    assert property (exp_en_r && !(drv_en_r && drv_line_r == exp_line_r)
                     |=> TRIG_BUS_OE_OUT[$past(exp_line_r)] &&
                     TRIG_BUS_OUT[$past(exp_line_r)] ==
                     $past(INT_START_IN))
    else $error("start trigger not shared on its bus line");

  a_div_clear:
    assert property (clr_c |=> !TB20_TICK_OUT [*4])
    else $error("middle tick too soon after a divider clear");

endmodule // tbg_timebase_top

// File: tb/tbg_peer_board.sv
// Peer board on the shared trigger bus, resolving each line's level
`timescale 1ns/1ps
module tbg_peer_board (
  input  wire logic       clk_in,   // System clock
  input  wire logic       rst_n_in, // Reset, active low
  input  wire logic [7:0] drv_in,   // Device drive values
  input  wire logic [7:0] oe_in,    // Device drive enables
  input  wire logic [2:0] sel_in,   // Line this peer locks to
  output logic      [7:0] bus_out,  // Resolved line levels
  output logic            ref_out   // Peer reference input
);
  logic [7:0] pat_r;

  // Undriven lines carry traffic that keeps changing
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pat_r <= 8'hA5;
    else
      pat_r <= pat_r * 8'h05 + 8'h3B;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      bus_out[i] = oe_in[i] ? drv_in[i] : pat_r[i];
  end

  assign ref_out = bus_out[sel_in];
endmodule // tbg_peer_board

// File: tb/tb_top.sv
// Self-checking bench for the timebase generation block
`timescale 1ns/1ps
module tb_top;
  import tbg_pkg::*;
  localparam int SDV = 5;
  logic clk, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, osc = 0, pll = 0, lock = 0, ext_ref;
  logic clk10 = 0, star_r = 0, star_o, star_oe, star_w, istart = 0;
  logic acq, t80, t20, t100, ai, ao, pr, ps, cnt_on = 0;
  logic r10, pq, pref;
  logic [5:0] programmable_function_input = '0;
  logic [7:0] tin, tout, toe;
  logic [1:0] ctr;
  logic [2:0] dl = '0;
  logic [11:0] ev;
  int n[12], fail_count = 0, cmp_count = 0, cyc = 0;

  assign star_w = star_oe ? star_o : star_r;
  // Event flags counted by the model: ticks in and out, reference edges
  assign ev = {r10 ^ pq, star_o ^ ps, pref ^ pr, ctr, ao, ai, t100, t20,
               t80, pll, osc};

  tbg_timebase_top #(.SDIV(SDV)) u_dut (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .OSC_TICK_IN(osc), .PLL_TICK_IN(pll),
    .PLL_LOCK_IN(lock), .EXT_REF_OUT(ext_ref), .TRIG_BUS_IN(tin),
    .TRIG_BUS_OUT(tout), .TRIG_BUS_OE_OUT(toe), .PXI_CLK10_IN(clk10),
    .PXI_STAR_IN(star_w), .PXI_STAR_OUT(star_o),
    .PXI_STAR_OE_OUT(star_oe), .PFI_IN(programmable_function_input), .INT_START_IN(istart),
    .ACQ_START_OUT(acq), .TB80_TICK_OUT(t80), .TB20_TICK_OUT(t20),
    .TB100K_TICK_OUT(t100), .REF10_CLK_OUT(r10), .AI_TB_TICK_OUT(ai),
    .AO_TB_TICK_OUT(ao), .CTR_TICK_OUT(ctr));

  tbg_peer_board u_peer (.clk_in(clk), .rst_n_in(rst_n), .drv_in(tout),
    .oe_in(toe), .sel_in(dl), .bus_out(tin), .ref_out(pref));

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    {clk10, star_r, programmable_function_input, istart} <= 9'($urandom);
    if (cnt_on)
      foreach (n[i]) n[i] += ev[i];
    pr = pref;
    ps = star_o;
    pq = r10;
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  // Level the device should pick up for a reference or start selection
  function automatic logic lvl(input bit a, input int s);
    if (!a)
      return s < 8 ? tin[s] : (s == 8 ? clk10 : star_w);
    case (s / 8)
      0: return istart;
      1: return tin[s % 8];
      2: return programmable_function_input[s % 8];
      default: return star_w;
    endcase
  endfunction

  task automatic follow(input bit a, input int s);
    logic x;
    repeat (3) @(posedge clk);
    @(negedge clk) x = lvl(a, s);
    repeat (6)
    begin
      @(negedge clk);
      if (a) chk(acq, x);
      else chk(ext_ref, x);
      x = lvl(a, s);
    end
  endtask

  task automatic run(input bit x, input bit lk, input logic [31:0] c,
                     input logic [31:0] cs);
    int f[4];
    @(posedge clk);
    rst_n <= 0;
    osc <= 0;
    pll <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    lock <= lk;
    dl = 3'($urandom);
    apb(1, OFS_CTRL, c | dl << 9, r, e);
    apb(1, OFS_CTR_SRC, cs, r, e);
    // Start export on the reference line: the reference must keep it
    apb(1, OFS_TRIG, 32'h100 | dl << 9, r, e);
    n = '{default: 0};
    cnt_on = 1;
    repeat (400) @(posedge clk) {osc, pll} <= 2'($urandom);
    @(posedge clk) {osc, pll} <= 2'b00;
    repeat (4) @(posedge clk);
    cnt_on = 0;
    f[0] = x ? (lk ? n[1] : 0) : n[0];
    f[1] = f[0] / MID_DIV;
    f[2] = f[1] / SDV;
    f[3] = 0;
    chk(n[2], f[0]);
    chk(n[3], f[1]);
    chk(n[4], f[2]);
    chk(n[5], c[13] ? f[2] : f[1]);
    chk(n[6], c[14] ? f[2] : f[1]);
    chk(n[7], f[cs[1:0]]);
    chk(n[8], f[cs[3:2]]);
    chk(n[9], n[0] / 4);
    chk(n[10], c[12] ? n[0] / 4 : 0);
    chk(n[11], n[0] / REF_HALF);
    chk(toe, 8'h01 << dl);
    apb(0, OFS_STATUS, 0, r, e);
    chk(r, 32'h1 << STAT_CONFLICT | 32'(!x || lk) << STAT_RUN |
           32'(x) << STAT_EXT | 32'(lk) << STAT_LOCK);
    $display("timebase run done src=%0d lock=%0d", x, lk);
  endtask

  task close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    int l;
    void'($urandom(32'h5A72));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    apb(0, OFS_CTRL, 0, r, e);
    chk(r, RST_CTRL);
    apb(0, OFS_CTR_SRC, 0, r, e);
    chk(r, RST_CTR_SRC);
    apb(0, OFS_TRIG, 0, r, e);
    chk(r, RST_TRIG);
    apb(0, 12'h010, 0, r, e);
    chk(e, 1);
    chk(r, 0);
    apb(1, OFS_STATUS, '1, r, e);
    chk(e, 0);
    apb(0, OFS_STATUS, 0, r, e);
    chk(r, 32'h1 << STAT_RUN);
    $display("register test done");
    for (int s = 0; s < 10; s++)
    begin
      apb(1, OFS_CTRL, s << 4 | 1, r, e);
      follow(0, s);
    end
    for (int k = 0; k < 4; k++)
    begin
      l = $urandom % 6;
      apb(1, OFS_TRIG, k | l << 2 | 32'h100 | (7 - l) << 9, r, e);
      follow(1, k * 8 + l);
      chk(toe, 8'h01 << (7 - l));
    end
    $display("routing test done");
    run(0, 0, 32'h1100, 32'h8);
    run(1, 1, 32'h6131, 32'hD);
    run(1, 0, 32'h0101, 32'h6);
    close_out();
  end
endmodule // tb_top
